// ---- verilog/irq_sfr_pkg.sv ----
// constants shared by the interrupt vector and special function register logic
// assumes a 32-bit axi4-lite register port and a 16-bit address space above it
package irq_sfr_pkg;

   // register word indices; the byte address is four times the index
   localparam logic [5:0] IDX_ENABLE_ONE = 6'h00;
   localparam logic [5:0] IDX_ENABLE_TWO = 6'h01;
   localparam logic [5:0] IDX_FLAG_ONE   = 6'h02;
   localparam logic [5:0] IDX_FLAG_TWO   = 6'h03;
   localparam logic [5:0] IDX_STATUS     = 6'h04;

   // enable byte field positions and implemented-bit mask
   localparam int         EN_WATCHDOG_BIT = 0;
   localparam int         EN_OSC_BIT      = 1;
   localparam int         EN_NMI_PIN_BIT  = 4;
   localparam int         EN_ACCESS_BIT   = 5;
   localparam logic [7:0] ENABLE_MASK     = 8'h33;
   localparam logic [7:0] ENABLE_RESET    = 8'h00;

   // flag byte field positions, implemented-bit mask and power-on value
   localparam int         FL_WATCHDOG_BIT = 0;
   localparam int         FL_OSC_BIT      = 1;
   localparam int         FL_POWER_BIT    = 2;
   localparam int         FL_EXT_RST_BIT  = 3;
   localparam int         FL_NMI_PIN_BIT  = 4;
   localparam logic [7:0] FLAG_MASK       = 8'h1F;
   localparam logic [7:0] FLAG_POR_RESET  = 8'h06;

   // status register field positions
   localparam int         ST_IRQ_BIT  = 16;
   localparam int         ST_DEEP_BIT = 17;

   // vector table: word address = base + 2 * priority
   localparam logic [15:0] VEC_BASE      = 16'hFFC0;
   localparam logic [15:0] VEC_USED_LOW  = 16'hFFE0;
   localparam logic [15:0] VEC_EMPTY     = 16'hFFFF;
   localparam logic [4:0]  PRIO_RESET    = 5'h1F;
   localparam logic [4:0]  PRIO_NMI      = 5'h1E;
   localparam logic [4:0]  PRIO_WATCHDOG = 5'h1A;
   localparam logic [4:0]  PRIO_TIMER_C0 = 5'h19;
   localparam logic [4:0]  PRIO_TIMER_C1 = 5'h18;
   localparam logic [4:0]  PRIO_SERIAL   = 5'h14;
   localparam logic [4:0]  PRIO_PORT_TWO = 5'h13;
   localparam logic [4:0]  PRIO_PORT_ONE = 5'h12;

   // legal instruction fetch ranges
   localparam logic [15:0] RAM_LOW   = 16'h0200;
   localparam logic [15:0] RAM_HIGH  = 16'h02FF;
   localparam logic [15:0] INFO_LOW  = 16'h1000;
   localparam logic [15:0] INFO_HIGH = 16'h10FF;
   localparam logic [15:0] CODE_LOW  = 16'hF000;

   // bus responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // core sequencing modes
   typedef enum logic [1:0] {
      MODE_CHECK  = 2'b00,
      MODE_VECTOR = 2'b01,
      MODE_RUN    = 2'b10,
      MODE_DEEP   = 2'b11
   } core_mode_t;

   // vector word for a priority level
   function automatic logic [15:0] vec_of(input logic [4:0] prio);
      vec_of = VEC_BASE + {10'h000, prio, 1'b0};
   endfunction

endpackage

// ---- verilog/sync_two_flop.sv ----
// two-flop synchroniser for one asynchronous level
// assumes d comes from a pin or another clock domain
module sync_two_flop
   import irq_sfr_pkg::*;
(
   // clock and reset
   input  wire logic aclk,
   input  wire logic aresetn,
   // level in and out
   input  wire logic d,
   output wire logic q
);

   typedef struct packed {
      logic s1;
      logic s2;
   } sync_state_t;

   sync_state_t st;
   sync_state_t next_st;

   // the first stage feeds only the second
   always_comb begin
      next_st.s1 = d;
      next_st.s2 = st.s1;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign q = st.s2;

endmodule

// ---- verilog/interrupt_vector_sfr_logic.sv ----
// interrupt vector selection, priority ordering and the enable/flag special function registers
// assumes an axi4-lite master on aclk, a cpu core that acknowledges vector fetches,
// and peripheral modules that keep their own interrupt flags
//
// The implementer's own choice: the AXI4-Lite slave port.
module interrupt_vector_sfr_logic
   import irq_sfr_pkg::*;
(
   // clock and power-on reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // axi4-lite write address and data
   input  wire logic        awvalid,
   output wire logic        awready,
   input  wire logic [7:0]  awaddr,
   input  wire logic        wvalid,
   output wire logic        wready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   // axi4-lite write response
   output wire logic        bvalid,
   input  wire logic        bready,
   output wire logic [1:0]  bresp,
   // axi4-lite read
   input  wire logic        arvalid,
   output wire logic        arready,
   input  wire logic [7:0]  araddr,
   output wire logic        rvalid,
   input  wire logic        rready,
   output wire logic [31:0] rdata,
   output wire logic [1:0]  rresp,
   // asynchronous pins
   input  wire logic        rst_nmi_pin,
   input  wire logic        osc_fault_raw,
   // reset and fault sources on aclk
   input  wire logic        pin_nmi_mode,
   input  wire logic        watchdog_expire,
   input  wire logic        watchdog_interval_mode,
   input  wire logic        storage_key_violation,
   input  wire logic        storage_access_violation_flag,
   input  wire logic        fetch_valid,
   input  wire logic [15:0] fetch_addr,
   // maskable peripheral flags
   input  wire logic        gie,
   input  wire logic        timer_compare0_flag,
   input  wire logic        timer_overflow_flag,
   input  wire logic        serial_if_flag,
   input  wire logic        serial_start_flag,
   input  wire logic [7:0]  port_one_change_flags,
   input  wire logic [7:0]  port_two_change_flags,
   // cpu vector fetch
   input  wire logic [15:0] reset_vector_word,
   input  wire logic        irq_ack,
   output wire logic        irq_req,
   output wire logic [15:0] irq_vector,
   output wire logic        lesser_system_reset,
   // deepest sleep controls
   output wire logic        cpu_off,
   output wire logic        clocks_off,
   output wire logic        osc_bias_off,
   output wire logic        xtal_stop
);

   typedef struct packed {
      core_mode_t  mode;
      logic        deep;
      logic        pin_prev;
      logic        lreset_pulse;
      logic        req;
      logic [15:0] vector;
      logic [7:0]  enable;
      logic [7:0]  flag;
      logic        awready;
      logic        wready;
      logic        aw_got;
      logic        w_got;
      logic [5:0]  waddr;
      logic [7:0]  wbyte;
      logic        wlane;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } blk_state_t;

   localparam blk_state_t ST_RESET = '{
      mode: MODE_CHECK, deep: 1'b0, pin_prev: 1'b0, lreset_pulse: 1'b0, req: 1'b0,
      vector: VEC_EMPTY, enable: ENABLE_RESET, flag: FLAG_POR_RESET,
      awready: 1'b1, wready: 1'b1, aw_got: 1'b0, w_got: 1'b0, waddr: IDX_ENABLE_ONE,
      wbyte: 8'h00, wlane: 1'b0, bvalid: 1'b0, bresp: RESP_OKAY,
      arready: 1'b1, rvalid: 1'b0, rdata: 32'h0000_0000, rresp: RESP_OKAY};

   blk_state_t st;
   blk_state_t next_st;

   logic pin_sync;
   logic osc_sync;

   // pins cross into aclk before anything looks at them
   sync_two_flop u_pin_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .d       (rst_nmi_pin),
      .q       (pin_sync)
   );

   sync_two_flop u_osc_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .d       (osc_fault_raw),
      .q       (osc_sync)
   );

   // register readback; unbuilt bits are masked to zero
   function automatic logic [31:0] read_word(input logic [5:0] idx, input blk_state_t s);
      unique case (idx)
         IDX_ENABLE_ONE: read_word = {24'h000000, s.enable & ENABLE_MASK};
         IDX_FLAG_ONE:   read_word = {24'h000000, s.flag & FLAG_MASK};
         IDX_STATUS:     read_word = {14'h0000, s.deep, s.req, s.vector};
         default:        read_word = 32'h0000_0000;
      endcase
   endfunction

   logic pin_fall;
   logic bad_fetch;
   logic lreset_now;
   logic acked;
   logic nmi_active;
   logic wdt_active;
   logic do_write;

   // reset sources: falling pin edge decides between reset and nmi by pin mode
   always_comb begin
      pin_fall  = st.pin_prev & ~pin_sync;
      bad_fetch = fetch_valid & ((fetch_addr < RAM_LOW)
                  | ((fetch_addr > RAM_HIGH) & (fetch_addr < INFO_LOW))
                  | ((fetch_addr > INFO_HIGH) & (fetch_addr < CODE_LOW)));
      lreset_now = (pin_fall & ~pin_nmi_mode) | (watchdog_expire & ~watchdog_interval_mode)
                  | storage_key_violation | bad_fetch;
      acked     = st.req & irq_ack;
      do_write  = st.aw_got & st.w_got & ~st.bvalid;
      // nmi group ignores gie entirely
      nmi_active = (st.flag[FL_NMI_PIN_BIT] & st.enable[EN_NMI_PIN_BIT])
                   | (st.flag[FL_OSC_BIT] & st.enable[EN_OSC_BIT])
                   | (storage_access_violation_flag & st.enable[EN_ACCESS_BIT]);
      // watchdog enable is meaningless outside interval mode
      wdt_active = st.flag[FL_WATCHDOG_BIT] & st.enable[EN_WATCHDOG_BIT]
                   & watchdog_interval_mode & gie;
   end

   // next state: bus slave, software writes, hardware sets, sequencing, vector choice
   always_comb begin
      next_st              = st;
      next_st.lreset_pulse = 1'b0;
      next_st.pin_prev     = pin_sync;

      // write address and data may arrive in either order
      if (awvalid && st.awready) begin
         next_st.aw_got  = 1'b1;
         next_st.awready = 1'b0;
         next_st.waddr   = awaddr[7:2];
      end
      if (wvalid && st.wready) begin
         next_st.w_got  = 1'b1;
         next_st.wready = 1'b0;
         next_st.wbyte  = wdata[7:0];
         next_st.wlane  = wstrb[0];
      end
      if (do_write) begin
         next_st.aw_got = 1'b0;
         next_st.w_got  = 1'b0;
         next_st.bvalid = 1'b1;
         next_st.bresp  = (st.waddr <= IDX_STATUS) ? RESP_OKAY : RESP_SLVERR;
         if (st.wlane && st.waddr == IDX_ENABLE_ONE) begin
            next_st.enable = st.wbyte & ENABLE_MASK;
         end
         if (st.wlane && st.waddr == IDX_FLAG_ONE) begin
            next_st.flag = st.wbyte & FLAG_MASK;
         end
      end
      if (st.bvalid && bready) begin
         next_st.bvalid  = 1'b0;
         next_st.awready = 1'b1;
         next_st.wready  = 1'b1;
      end

      // one read at a time; answer one cycle after the address is taken
      if (arvalid && st.arready) begin
         next_st.arready = 1'b0;
         next_st.rvalid  = 1'b1;
         next_st.rdata   = read_word(araddr[7:2], st);
         next_st.rresp   = (araddr[7:2] <= IDX_STATUS) ? RESP_OKAY : RESP_SLVERR;
      end
      if (st.rvalid && rready) begin
         next_st.rvalid  = 1'b0;
         next_st.arready = 1'b1;
      end

      // a taken watchdog vector consumes its single-source flag
      if (acked && st.mode == MODE_RUN && st.vector == vec_of(PRIO_WATCHDOG)) begin
         next_st.flag[FL_WATCHDOG_BIT] = 1'b0;
      end

      // core sequencing after power-up and lesser resets
      unique case (st.mode)
         MODE_CHECK: begin
            next_st.mode = (reset_vector_word == VEC_EMPTY) ? MODE_DEEP : MODE_VECTOR;
         end
         MODE_VECTOR: begin
            if (acked) begin
               next_st.mode = MODE_RUN;
            end
         end
         MODE_RUN: begin
            next_st.mode = MODE_RUN;
         end
         MODE_DEEP: begin
            next_st.mode = MODE_DEEP; // only a reset leaves it
         end
      endcase

      // lesser reset: rw-0/rw-1 bits forced, power-on-only bits untouched
      if (lreset_now) begin
         next_st.lreset_pulse         = 1'b1;
         next_st.mode                 = MODE_VECTOR;
         next_st.enable               = ENABLE_RESET;
         next_st.flag[FL_NMI_PIN_BIT] = 1'b0;
         next_st.flag[FL_OSC_BIT]     = 1'b1;
      end

      // hardware sets come last so they win over a same-cycle clear
      if (watchdog_expire) begin
         next_st.flag[FL_WATCHDOG_BIT] = 1'b1;
      end
      if (osc_sync) begin
         next_st.flag[FL_OSC_BIT] = 1'b1;
      end
      if (pin_fall && pin_nmi_mode) begin
         next_st.flag[FL_NMI_PIN_BIT] = 1'b1;
      end
      if (pin_fall && !pin_nmi_mode) begin
         next_st.flag[FL_EXT_RST_BIT] = 1'b1;
      end

      next_st.deep = (next_st.mode == MODE_DEEP);

      // vector choice in fixed priority; one idle cycle after each acknowledge
      next_st.req = 1'b0;
      if (next_st.mode == MODE_VECTOR) begin
         next_st.req    = 1'b1;
         next_st.vector = vec_of(PRIO_RESET);
      end else if (next_st.mode == MODE_RUN && !acked) begin
         next_st.req = 1'b1;
         if (nmi_active) begin
            next_st.vector = vec_of(PRIO_NMI);
         end else if (wdt_active) begin
            next_st.vector = vec_of(PRIO_WATCHDOG);
         end else if (gie && timer_compare0_flag) begin
            next_st.vector = vec_of(PRIO_TIMER_C0);
         end else if (gie && timer_overflow_flag) begin
            next_st.vector = vec_of(PRIO_TIMER_C1);
         end else if (gie && (serial_if_flag || serial_start_flag)) begin
            next_st.vector = vec_of(PRIO_SERIAL);
         end else if (gie && (|port_two_change_flags)) begin
            next_st.vector = vec_of(PRIO_PORT_TWO);
         end else if (gie && (|port_one_change_flags)) begin
            next_st.vector = vec_of(PRIO_PORT_ONE);
         end else begin
            next_st.req = 1'b0;
         end
      end
   end

   // power-on reset loads every bit, including the power-on flag
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st <= ST_RESET;
      end else begin
         st <= next_st;
      end
   end

   // outputs straight from the state register
   assign awready             = st.awready;
   assign wready              = st.wready;
   assign bvalid              = st.bvalid;
   assign bresp               = st.bresp;
   assign arready             = st.arready;
   assign rvalid              = st.rvalid;
   assign rdata               = st.rdata;
   assign rresp               = st.rresp;
   assign irq_req             = st.req;
   assign irq_vector          = st.vector;
   assign lesser_system_reset = st.lreset_pulse;
   assign cpu_off             = st.deep;
   assign clocks_off          = st.deep;
   assign osc_bias_off        = st.deep;
   assign xtal_stop           = st.deep;

   // checks on the vector logic and register behaviour
   a_vector_in_range: assert property (@(posedge aclk) disable iff (!aresetn)
      irq_req |-> (irq_vector >= VEC_USED_LOW)) else $error("vector below used range");

   a_empty_word_sleeps: assert property (@(posedge aclk) disable iff (!aresetn)
      (st.mode == MODE_CHECK && reset_vector_word == VEC_EMPTY && !lreset_now) |=> (cpu_off && !irq_req))
      else $error("empty reset word did not enter deepest sleep");

   a_deep_all_off: assert property (@(posedge aclk) disable iff (!aresetn)
      cpu_off |-> (clocks_off && osc_bias_off && xtal_stop && !irq_req)) else $error("deepest sleep incomplete");

   a_lreset_vector: assert property (@(posedge aclk) disable iff (!aresetn)
      lesser_system_reset |-> (irq_req && irq_vector == 16'hFFFE && st.enable == 8'h00 && st.flag[FL_OSC_BIT]))
      else $error("lesser reset did not force reset vector and register values");

   a_nmi_ignores_gie: assert property (@(posedge aclk) disable iff (!aresetn)
      (st.mode == MODE_RUN && nmi_active && !gie && !irq_ack && !lreset_now) |=> (irq_req && irq_vector == 16'hFFFC))
      else $error("nonmaskable group not served without gie");

   a_wdt_interval_only: assert property (@(posedge aclk) disable iff (!aresetn)
      (irq_req && irq_vector == 16'hFFF4) |-> $past(watchdog_interval_mode)) else $error("watchdog vector outside interval mode");

   a_bad_fetch_resets: assert property (@(posedge aclk) disable iff (!aresetn)
      (fetch_valid && fetch_addr < 16'h0200) |=> lesser_system_reset) else $error("illegal fetch gave no reset");

   a_port_order: assert property (@(posedge aclk) disable iff (!aresetn)
      (irq_req && irq_vector == 16'hFFE4) |-> $past(port_two_change_flags) == 8'h00) else $error("port one served ahead of port two");

   a_unbuilt_zero: assert property (@(posedge aclk) disable iff (!aresetn)
      ((st.enable & ~ENABLE_MASK) == 8'h00) && ((st.flag & ~FLAG_MASK) == 8'h00)) else $error("unbuilt bit set");

endmodule

// ---- tb/cpu_model.sv ----
// cpu core partner: takes each offered vector after a set delay and records it
// assumes irq_req and irq_vector come from the block under test on aclk
module cpu_model
   import irq_sfr_pkg::*;
(
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // vector port
   input  wire logic        irq_req,
   input  wire logic [15:0] irq_vector,
   output logic             irq_ack,
   // bench controls and record of taken vectors
   input  wire logic        ack_on,
   input  wire logic [3:0]  ack_delay,
   output logic [15:0]      last_vector,
   output logic [7:0]       takes
);
   timeunit 1ns;
   timeprecision 100ps;

   logic [3:0] wait_cnt;

   // ack is held until an edge that sees irq_req high; the vector is taken at that edge
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_ack     <= 1'b0;
         wait_cnt    <= 4'h0;
         takes       <= 8'h00;
         last_vector <= 16'h0000;
      end else if (irq_ack && irq_req) begin
         irq_ack     <= 1'b0;
         wait_cnt    <= 4'h0;
         takes       <= takes + 8'h01;
         last_vector <= irq_vector;
      end else if (irq_req && ack_on) begin
         // a slow core leaves time for the source to change its flags
         if (wait_cnt == ack_delay) begin
            irq_ack <= 1'b1;
         end else begin
            wait_cnt <= wait_cnt + 4'h1;
         end
      end else begin
         wait_cnt <= 4'h0;
      end
   end
endmodule

// ---- tb/tb.sv ----
// self-checking bench for the interrupt vector and special function register block
// assumes a 40 MHz aclk; the cpu model acknowledges vectors, the bench plays the peripherals
module tb
   import irq_sfr_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic        rst_nmi_pin = 1, osc_fault_raw = 0, pin_nmi_mode = 0, watchdog_expire = 0, gie = 0;
   logic        watchdog_interval_mode = 0, storage_key_violation = 0, fetch_valid = 0, ack_on = 1;
   logic        timer_compare0_flag = 0, timer_overflow_flag = 0, serial_if_flag = 0, serial_start_flag = 1'b0;
   logic        storage_access_violation_flag = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, irq_req, irq_ack, lesser_system_reset;
   logic        cpu_off, clocks_off, osc_bias_off, xtal_stop;
   logic [7:0]  awaddr = 0, araddr = 0, port_one_change_flags = 0, port_two_change_flags = 0, takes;
   logic [31:0] wdata = 0, rdata;
   logic [1:0]  bresp, rresp;
   logic [15:0] fetch_addr = 0, reset_vector_word = 16'h1234, irq_vector, last_vector;
   int          mismatches = 0, n_tests = 0;

   interrupt_vector_sfr_logic uut (.wstrb(4'hF), .*);
   cpu_model pm (.ack_delay(4'h3), .*);

   // free-running system clock
   initial begin
      forever #12.5 aclk = ~aclk;
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic finish_test;
      $display("mismatches %0d n_tests %0d", mismatches, n_tests);
      if (mismatches == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // one write: address and data offered together, each released when taken
   // bready and rready stay high after a transfer, so a back-to-back call never re-raises them in one step;
   // only the hang guard ends a wait for the answer
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awvalid && awready) begin
            awvalid <= 1'b0;
         end
         if (wvalid && wready) begin
            wvalid <= 1'b0;
         end
      end while (!(bvalid && bready));
      check("bresp", bresp, er);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arvalid && arready) begin
            arvalid <= 1'b0;
         end
      end while (!(rvalid && rready));
      check("rdata", rdata, exp);
      check("rresp", rresp, er);
   endtask

   task automatic reset_dut(input logic [15:0] rv);
      aresetn <= 1'b0;
      reset_vector_word <= rv;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
   endtask

   // bounded wait for the cpu model to take a new vector
   task automatic wait_take(input logic [15:0] exp);
      logic [7:0] k;
      int         n;
      k = takes;
      n = 0;
      while (takes == k && n < 60) begin
         @(posedge aclk);
         n++;
      end
      // a timeout must not pass on a vector left from an earlier take
      check("taken", takes != k, 1'b1);
      check("vector", last_vector, exp);
   endtask

   // fires one reset cause and watches for the lesser reset pulse
   task automatic lreset(input int s, input logic exp);
      logic seen;
      seen = 1'b0;
      case (s)
         0: begin fetch_valid <= 1'b1; fetch_addr <= 16'h0100; end
         1: begin fetch_valid <= 1'b1; fetch_addr <= 16'hF000; end
         2: storage_key_violation <= 1'b1;
         3: watchdog_expire <= 1'b1;
         default: rst_nmi_pin <= 1'b0;
      endcase
      @(posedge aclk);
      fetch_valid <= 1'b0;
      storage_key_violation <= 1'b0;
      watchdog_expire <= 1'b0;
      // the pin path runs through a two-flop synchroniser, so allow six edges
      repeat (6) begin
         @(posedge aclk);
         seen = seen | lesser_system_reset;
      end
      rst_nmi_pin <= 1'b1;
      repeat (4) @(posedge aclk);
      check("lesser reset", seen, exp);
   endtask

   task automatic t_boot;
      reset_dut(16'h1234);
      wait_take(16'hFFFE);
      rd(8'h00, 32'h00, RESP_OKAY);
      rd(8'h08, 32'h06, RESP_OKAY);
      wr(8'h00, 32'hFF, RESP_OKAY);
      rd(8'h00, 32'h33, RESP_OKAY);
      wr(8'h04, 32'hFF, RESP_OKAY);
      rd(8'h04, 32'h00, RESP_OKAY);
      rd(8'h20, 32'h00, RESP_SLVERR);
      wr(8'h00, 32'h00, RESP_OKAY);
      wr(8'h08, 32'h00, RESP_OKAY);
      rd(8'h08, 32'h00, RESP_OKAY);
   endtask

   // nonmaskable group with the general enable off
   task automatic t_nmi;
      pin_nmi_mode <= 1'b1;
      wr(8'h00, 32'h10, RESP_OKAY);
      rst_nmi_pin <= 1'b0;
      wait_take(16'hFFFC);
      rd(8'h08, 32'h10, RESP_OKAY);
      rst_nmi_pin <= 1'b1;
      wr(8'h00, 32'h00, RESP_OKAY);
      wr(8'h08, 32'h00, RESP_OKAY);
      osc_fault_raw <= 1'b1;
      repeat (4) @(posedge aclk);
      osc_fault_raw <= 1'b0;
      repeat (4) @(posedge aclk);
      rd(8'h08, 32'h02, RESP_OKAY);
      wr(8'h00, 32'h02, RESP_OKAY);
      wait_take(16'hFFFC);
      wr(8'h00, 32'h00, RESP_OKAY);
      wr(8'h08, 32'h00, RESP_OKAY);
      // the access violation flag lives in the storage module and shares the nmi vector
      storage_access_violation_flag <= 1'b1;
      wr(8'h00, 32'h20, RESP_OKAY);
      wait_take(16'hFFFC);
      storage_access_violation_flag <= 1'b0;
      wr(8'h00, 32'h00, RESP_OKAY);
   endtask

   // all maskable sources at once, served strictly by priority
   task automatic t_prio;
      logic [15:0] ord [7] = '{16'hFFF4, 16'hFFF2, 16'hFFF0, 16'hFFE8, 16'hFFE8, 16'hFFE6, 16'hFFE4};
      ack_on <= 1'b0;
      watchdog_interval_mode <= 1'b1;
      wr(8'h00, 32'h01, RESP_OKAY);
      timer_compare0_flag <= 1'b1;
      timer_overflow_flag <= 1'b1;
      serial_if_flag <= 1'b1;
      serial_start_flag <= 1'b1;
      port_one_change_flags <= 8'h01;
      port_two_change_flags <= 8'h80;
      watchdog_expire <= 1'b1;
      @(posedge aclk);
      watchdog_expire <= 1'b0;
      repeat (4) @(posedge aclk);
      check("masked", irq_req, 1'b0);
      gie <= 1'b1;
      ack_on <= 1'b1;
      // the serial vector is taken twice: once for each of its two flags
      for (int i = 0; i < 7; i++) begin
         wait_take(ord[i]);
         case (i)
            1: timer_compare0_flag <= 1'b0;
            2: timer_overflow_flag <= 1'b0;
            3: serial_if_flag <= 1'b0;
            4: serial_start_flag <= 1'b0;
            5: port_two_change_flags <= 8'h00;
            6: port_one_change_flags <= 8'h00;
            default: ;
         endcase
      end
      gie <= 1'b0;
   endtask

   // reset causes, then what survives a lesser reset
   task automatic t_lreset;
      wr(8'h08, 32'h04, RESP_OKAY);
      wr(8'h00, 32'h33, RESP_OKAY);
      pin_nmi_mode <= 1'b0;
      watchdog_interval_mode <= 1'b0;
      for (int s = 0; s < 5; s++) lreset(s, s != 1);
      rd(8'h00, 32'h00, RESP_OKAY);
      rd(8'h08, 32'h0F, RESP_OKAY);
   endtask

   task automatic t_sleep;
      reset_dut(16'hFFFF);
      repeat (3) @(posedge aclk);
      check("sleep", {cpu_off, clocks_off, osc_bias_off, xtal_stop, irq_req}, 5'h1E);
      rd(8'h08, 32'h06, RESP_OKAY);
      // status: deep bit set, no request, vector left at its empty value
      rd(8'h10, 32'h0002_FFFF, RESP_OKAY);
   endtask

   initial begin
      t_boot;
      t_nmi;
      t_prio;
      t_lreset;
      t_sleep;
      finish_test;
   end

   // hang guard, well beyond the few hundred cycles the scenarios need
   initial begin
      repeat (20000) @(posedge aclk);
      mismatches++;
      finish_test;
   end
endmodule
